// ---- rem_addr_decode.sv ----
`timescale 1ns/1ns
module rem_addr_decode
  import rem_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic [1:0] mode,
  input wire logic ram_en,
  output rem_region_t region,
  output logic is_vector
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  logic expanded;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  always_comb begin
    expanded = (mode == MODE_EXP_NOROM) || (mode == MODE_EXP_ROM);
    is_vector = in_rng(addr, ADDR_VEC_LO, ADDR_VEC_HI);
    region = RGN_NONE;
    if (in_rng(addr, ADDR_REG_LO, ADDR_REG_HI)) begin
      region = RGN_IOREG;
    end else if (in_rng(addr, ADDR_RAM_LO, ADDR_RAM_HI)) begin
      // Single-chip mode has no bus to fall back to
      region = ram_en ? RGN_RAM : (expanded ? RGN_EXT : RGN_NONE);
    end else if (in_rng(addr, ADDR_EXTW_LO, ADDR_EXTW_HI)) begin
      region = expanded ? RGN_EXT : RGN_NONE;
    end else begin
      unique case (mode)
        MODE_EXP_NOROM: begin
          region = RGN_EXT;
        end
        MODE_EXP_ROM: begin
          if (addr <= ADDR_ROM_HI) begin
            region = RGN_ROM;
          end else if (addr >= ADDR_M2_EXT_LO) begin
            region = RGN_EXT;
          end else begin
            region = RGN_NONE;
          end
        end
        MODE_SINGLE: begin
          region = (addr <= ADDR_ROM_HI) ? RGN_ROM : RGN_NONE;
        end
        default: begin
          // Strap code 0 maps only registers and on-chip RAM; nothing else answers
          region = RGN_NONE;
        end
      endcase
    end
  end
endmodule

// ---- rem_ext_model.sv ----
`timescale 1ns/1ns
// ------------------------------
// Reset source and vector memory
// ------------------------------
module rem_ext_model (
  input wire logic clock,
  input wire logic vec_rd_req,
  output logic vec_rd_valid,
  output logic [15:0] vec_rd_data,
  output logic reset_input_n
);
  int lat = 0;
  int cnt = 0;
  logic [15:0] word = 16'hA55A;
  initial begin
    vec_rd_valid = 1'b0;
    vec_rd_data = 16'h0000;
    reset_input_n = 1'b0;
  end
  task automatic hold_reset(input int n);
    @(negedge clock);
    reset_input_n = 1'b0;
    repeat (n) @(negedge clock);
    reset_input_n = 1'b1;
  endtask
  // Idle data toggles so a stale capture cannot pass
  always @(negedge clock) begin
    vec_rd_valid <= 1'b0;
    vec_rd_data <= ~vec_rd_data;
    if (vec_rd_req && !vec_rd_valid) begin
      cnt <= (cnt == lat) ? 0 : cnt + 1;
      if (cnt == lat) begin
        vec_rd_valid <= 1'b1;
        vec_rd_data <= word;
      end
    end
  end
endmodule

// ---- rem_pkg.sv ----
package rem_pkg;
  // ------------------------------------------------------------
  // Address map boundaries
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_VEC_LO = 16'h0000;
  localparam logic [15:0] ADDR_VEC_HI = 16'h004B;
  localparam logic [15:0] ADDR_ROM_HI = 16'hBFFF;
  localparam logic [15:0] ADDR_M2_EXT_LO = 16'hEF80;
  localparam logic [15:0] ADDR_RAM_LO = 16'hF780;
  localparam logic [15:0] ADDR_RAM_HI = 16'hFF7F;
  localparam logic [15:0] ADDR_EXTW_LO = 16'hFF80;
  localparam logic [15:0] ADDR_EXTW_HI = 16'hFF87;
  localparam logic [15:0] ADDR_REG_LO = 16'hFF88;
  localparam logic [15:0] ADDR_REG_HI = 16'hFFFF;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;

  // ------------------------------------------------------------
  // Operating modes, as read from the two mode pins
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_EXP_NOROM = 2'h1;
  localparam logic [1:0] MODE_EXP_ROM = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;

  // ------------------------------------------------------------
  // Timing and reset values
  // ------------------------------------------------------------
  localparam int WDT_PULSE_CLKS = 518;
  localparam int WDT_CNT_W = 10;
  localparam logic [WDT_CNT_W-1:0] WDT_CNT_LOAD = WDT_CNT_W'(WDT_PULSE_CLKS - 1);
  localparam logic RAM_EN_RST = 1'b1;
  localparam logic CCR_I_RST = 1'b1;

  // ------------------------------------------------------------
  // Decoded target of an address
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    RGN_NONE = 5'h01,
    RGN_ROM = 5'h02,
    RGN_RAM = 5'h04,
    RGN_IOREG = 5'h08,
    RGN_EXT = 5'h10
  } rem_region_t;
endpackage

// ---- rem_properties.sv ----
`timescale 1ns/1ns
// ---------------------------------
// Reset sequence and decode checks
// ---------------------------------
module rem_properties
  import rem_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_input_n,
  input wire logic instr_boundary,
  input wire logic instr_was_cc_op,
  input wire logic exc_seq_done,
  input wire logic vec_rd_valid,
  input wire logic [15:0] vec_rd_data,
  input wire logic [15:0] cpu_addr,
  input wire logic core_hold,
  input wire logic ccr_i_set,
  input wire logic vec_rd_req,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic nmi_accept,
  input wire logic irq_accept,
  input wire logic int_blocked,
  input wire logic wdt_reset_active,
  input wire logic [1:0] mode_field,
  input wire logic mode_select_pin_hi,
  input wire logic mode_select_pin_lo,
  input wire rem_region_t addr_region
);
  logic [9:0] wcnt_r;
  logic acc;
  logic samp;
  assign acc = nmi_accept | irq_accept;
  assign samp = instr_boundary & ~instr_was_cc_op | exc_seq_done;
  // Counter, since a 518-cycle repetition is too long to unroll
  always_ff @(posedge clock) begin
    wcnt_r <= (rst || !wdt_reset_active) ? 10'h000 : wcnt_r + 10'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence pin_rise;
    !reset_input_n ##1 reset_input_n;
  endsequence
  sequence init_step;
    ##1 ccr_i_set && vec_rd_req;
  endsequence
  pin_prio_a: assert property (!reset_input_n |=> core_hold && !acc)
    else $error("reset did not take priority");
  rise_start_a: assert property (pin_rise |=> init_step)
    else $error("no init step after pin rise");
  pc_load_a: assert property (reset_input_n && vec_rd_req && vec_rd_valid |=>
    pc_load && pc_value == $past(vec_rd_data)) else $error("vector word not loaded");
  first_blk_a: assert property (pc_load |-> int_blocked)
    else $error("interrupts open before first instruction");
  cc_blk_a: assert property (int_blocked && instr_boundary && instr_was_cc_op |=>
    int_blocked && !acc) else $error("block lifted by cc instruction");
  acc_point_a: assert property (acc |-> $past(samp))
    else $error("accept outside a sampling point");
  wdt_width_a: assert property ($fell(wdt_reset_active) |->
    wcnt_r == 10'h206 || !$past(reset_input_n) || $past(rst)) else $error("pulse too short");
  wdt_cap_a: assert property (wdt_reset_active |-> wcnt_r < 10'h206)
    else $error("pulse too long");
  mode_pin_a: assert property (!$past(rst) |-> mode_field[1] == $past(mode_select_pin_hi)
    && mode_field[0] == $past(mode_select_pin_lo)) else $error("mode field stale");
  reg_field_a: assert property (!$past(rst) && $past(cpu_addr) >= ADDR_REG_LO &&
    $past(mode_field) != 2'h0 |-> addr_region == RGN_IOREG) else $error("register field");
endmodule

// ---- rem_reset_seq.sv ----
`timescale 1ns/1ns
module rem_reset_seq
  import rem_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_input_n,
  input wire logic wdt_reset_req,
  input wire logic mode_select_pin_hi,
  input wire logic mode_select_pin_lo,
  input wire logic instr_boundary,
  input wire logic instr_was_cc_op,
  input wire logic exc_seq_done,
  input wire logic ccr_i_mask,
  input wire logic nmi_pending,
  input wire logic irq_pending,
  input wire logic standby_entry,
  input wire logic ram_enable_wr,
  input wire logic ram_enable_wdata,
  input wire logic vec_rd_valid,
  input wire logic [15:0] vec_rd_data,
  input wire logic [15:0] cpu_addr,
  output logic core_hold,
  output logic periph_init,
  output logic ccr_i_set,
  output logic vec_rd_req,
  output logic [15:0] vec_rd_addr,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic core_run,
  output logic nmi_accept,
  output logic irq_accept,
  output logic exc_active,
  output logic int_blocked,
  output logic wdt_reset_active,
  output logic reset_from_pin,
  output logic onchip_ram_enable,
  output logic [1:0] mode_field,
  output rem_region_t addr_region,
  output logic addr_is_vector
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_WDT = 6'h02,
    ST_INIT = 6'h04,
    ST_FETCH = 6'h08,
    ST_RUN = 6'h10,
    ST_EXC = 6'h20
  } rem_fsm_t;

  typedef struct packed {
    rem_fsm_t fsm;
    logic pin_prev;
    logic [WDT_CNT_W-1:0] wdt_cnt;
    logic ram_en;
    logic [1:0] mode;
    logic block_all;
    logic [15:0] pc;
    logic pc_load;
    logic ccr_set;
    logic nmi_acc;
    logic irq_acc;
    logic from_pin;
    rem_region_t region;
    logic is_vec;
  } rem_state_t;

  rem_state_t s_r;
  rem_state_t s_nxt;
  rem_region_t dec_region;
  logic dec_is_vec;
  logic may_sample;
  logic take_nmi;
  logic take_irq;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic in_reset(input rem_fsm_t f);
    return (f == ST_RESET) || (f == ST_WDT);
  endfunction

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  rem_addr_decode u_dec (
    .addr(cpu_addr),
    .mode(s_r.mode),
    .ram_en(s_r.ram_en),
    .region(dec_region),
    .is_vector(dec_is_vec)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.pin_prev = reset_input_n;
    s_nxt.mode = {mode_select_pin_hi, mode_select_pin_lo};
    s_nxt.region = dec_region;
    s_nxt.is_vec = dec_is_vec;
    s_nxt.pc_load = 1'b0;
    s_nxt.ccr_set = 1'b0;
    s_nxt.nmi_acc = 1'b0;
    s_nxt.irq_acc = 1'b0;
    // Standby entry deliberately not looked at: RAM enable survives it
    if (ram_enable_wr) begin
      s_nxt.ram_en = ram_enable_wdata;
    end
    // Sampling points: end of a non condition-code instruction, or end of an exception sequence
    may_sample = ((s_r.fsm == ST_RUN) && instr_boundary && !instr_was_cc_op) ||
                 ((s_r.fsm == ST_EXC) && exc_seq_done);
    // First-instruction guard clears only on a non condition-code boundary
    if (s_r.fsm == ST_RUN && instr_boundary && !instr_was_cc_op) begin
      s_nxt.block_all = 1'b0;
    end
    // Clearing boundary ends the first instruction, so it may already sample
    take_nmi = may_sample && !s_nxt.block_all && nmi_pending;
    take_irq = may_sample && !s_nxt.block_all && !nmi_pending && irq_pending &&
               !ccr_i_mask;
    unique case (s_r.fsm)
      ST_RESET: begin
        if (reset_input_n && !s_r.pin_prev) begin
          s_nxt.fsm = ST_INIT;
        end
      end
      ST_WDT: begin
        if (s_r.wdt_cnt == '0) begin
          s_nxt.fsm = ST_INIT;
        end else begin
          s_nxt.wdt_cnt = s_r.wdt_cnt - 1'b1;
        end
      end
      ST_INIT: begin
        s_nxt.ccr_set = CCR_I_RST;
        s_nxt.fsm = ST_FETCH;
      end
      ST_FETCH: begin
        if (vec_rd_valid) begin
          s_nxt.pc = vec_rd_data;
          s_nxt.pc_load = 1'b1;
          s_nxt.fsm = ST_RUN;
        end
      end
      ST_RUN: begin
        if (take_nmi || take_irq) begin
          s_nxt.fsm = ST_EXC;
        end
      end
      ST_EXC: begin
        if (exc_seq_done && !(take_nmi || take_irq)) begin
          s_nxt.fsm = ST_RUN;
        end
      end
    endcase
    s_nxt.nmi_acc = take_nmi;
    s_nxt.irq_acc = take_irq;
    // Reset sources override everything but the ST_INIT ccr_set pulse, the pin above the watchdog
    if (wdt_reset_req && !in_reset(s_r.fsm)) begin
      s_nxt.fsm = ST_WDT;
      s_nxt.wdt_cnt = WDT_CNT_LOAD;
      s_nxt.from_pin = 1'b0;
    end
    if (!reset_input_n) begin
      s_nxt.fsm = ST_RESET;
      s_nxt.from_pin = 1'b1;
    end
    if (in_reset(s_nxt.fsm)) begin
      s_nxt.ram_en = RAM_EN_RST;
      s_nxt.block_all = 1'b1;
      s_nxt.nmi_acc = 1'b0;
      s_nxt.irq_acc = 1'b0;
      s_nxt.pc_load = 1'b0;
      s_nxt.pc = RESET_VECTOR_ADDR;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '{fsm: ST_RESET, pin_prev: 1'b0, wdt_cnt: '0, ram_en: RAM_EN_RST,
               mode: 2'h0, block_all: 1'b1, pc: RESET_VECTOR_ADDR, pc_load: 1'b0,
               ccr_set: 1'b0, nmi_acc: 1'b0, irq_acc: 1'b0, from_pin: 1'b1,
               region: RGN_NONE, is_vec: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign core_hold = in_reset(s_r.fsm) || (s_r.fsm == ST_INIT) ||
                     (s_r.fsm == ST_FETCH);
  assign periph_init = in_reset(s_r.fsm) || (s_r.fsm == ST_INIT);
  assign ccr_i_set = s_r.ccr_set;
  assign vec_rd_req = (s_r.fsm == ST_FETCH);
  assign vec_rd_addr = RESET_VECTOR_ADDR;
  assign pc_load = s_r.pc_load;
  assign pc_value = s_r.pc;
  assign core_run = (s_r.fsm == ST_RUN) || (s_r.fsm == ST_EXC);
  assign nmi_accept = s_r.nmi_acc;
  assign irq_accept = s_r.irq_acc;
  assign exc_active = (s_r.fsm == ST_EXC);
  assign int_blocked = s_r.block_all;
  assign wdt_reset_active = (s_r.fsm == ST_WDT);
  assign reset_from_pin = s_r.from_pin;
  assign onchip_ram_enable = s_r.ram_en;
  assign mode_field = s_r.mode;
  assign addr_region = s_r.region;
  assign addr_is_vector = s_r.is_vec;
endmodule

// ---- tb_reset_exception_memmap.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
// ------------------------------
// Bench
// ------------------------------
module tb_reset_exception_memmap;
  import rem_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wdt_reset_req, mode_select_pin_hi, mode_select_pin_lo, instr_boundary, instr_was_cc_op;
  logic exc_seq_done, ccr_i_mask, nmi_pending, irq_pending, standby_entry, ram_enable_wr;
  logic ram_enable_wdata, reset_input_n, vec_rd_valid, core_hold, periph_init, ccr_i_set;
  logic vec_rd_req, pc_load, core_run, nmi_accept, irq_accept, exc_active, int_blocked;
  logic wdt_reset_active, reset_from_pin, onchip_ram_enable, addr_is_vector;
  logic [15:0] vec_rd_data, cpu_addr, vec_rd_addr, pc_value;
  logic [1:0] mode_field;
  rem_region_t addr_region;
  int n_mismatch = 0;
  int n_checks = 0;
  always #5 clock = ~clock;
  rem_reset_seq i_rem_reset_seq (.*);
  rem_ext_model i_rem_ext_model (.*);
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < 50) begin n++; @(negedge clock); end
    `CHK("pc", i_rem_ext_model.word, pc_value)
    `CHK("blk", 1'b1, int_blocked)
    `CHK("ram_en", 1'b1, onchip_ram_enable)
    `CHK("run", 1'b1, core_run)
    `CHK("hold_off", 1'b0, core_hold)
  endtask
  // Boundary lands on the same edge as the pin falling
  task automatic pin_reset();
    fork
      i_rem_ext_model.hold_reset(10);
      begin
        @(negedge clock);
        instr_boundary = 1'b1;
        @(negedge clock);
        instr_boundary = 1'b0;
        `CHK("acc", 1'b0, nmi_accept | irq_accept)
        `CHK("hold", 1'b1, core_hold)
        `CHK("periph_init", 1'b1, periph_init)
        `CHK("src_pin", 1'b1, reset_from_pin)
      end
    join
    wait_run();
  endtask
  task automatic ev(input logic b, input logic cc, input logic nmi_e, input logic irq_e);
    @(negedge clock);
    {instr_boundary, exc_seq_done, instr_was_cc_op} = {b, !b, cc};
    @(negedge clock);
    {instr_boundary, exc_seq_done} = 2'h0;
    `CHK("nmi", nmi_e, nmi_accept)
    `CHK("irq", irq_e, irq_accept)
  endtask
  task automatic t_int();
    nmi_pending = 1'b1;
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b1, 1'b0);
    {nmi_pending, irq_pending} = 2'h1;
    ev(1'b0, 1'b0, 1'b0, 1'b1);
    {irq_pending, ccr_i_mask} = 2'h3;
    ev(1'b0, 1'b0, 1'b0, 1'b0);
    nmi_pending = 1'b1;
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b1, 1'b0);
    ccr_i_mask = 1'b0;
    ev(1'b0, 1'b0, 1'b1, 1'b0);
    nmi_pending = 1'b0;
    ev(1'b0, 1'b0, 1'b0, 1'b1);
    irq_pending = 1'b0;
    ev(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic d(input logic [1:0] m, input logic r, input logic [15:0] a, input rem_region_t e);
    @(negedge clock);
    {mode_select_pin_hi, mode_select_pin_lo, ram_enable_wr, ram_enable_wdata} = {m, 1'b1, r};
    cpu_addr = a;
    repeat (2) @(negedge clock);
    ram_enable_wr = 1'b0;
    `CHK("region", e, addr_region)
    `CHK("vector", a <= ADDR_VEC_HI, addr_is_vector)
  endtask
  task automatic t_wdt();
    int n;
    n = 0;
    @(negedge clock);
    wdt_reset_req = 1'b1;
    @(negedge clock);
    wdt_reset_req = 1'b0;
    while (wdt_reset_active === 1'b1 && n < 600) begin n++; @(negedge clock); end
    `CHK("wdt_len", WDT_PULSE_CLKS, n)
    `CHK("src_wdt", 1'b0, reset_from_pin)
    wait_run();
  endtask
  initial begin
    {wdt_reset_req, instr_boundary, instr_was_cc_op, exc_seq_done, ccr_i_mask} = 5'h00;
    {nmi_pending, irq_pending, standby_entry, ram_enable_wr, ram_enable_wdata} = 5'h00;
    {mode_select_pin_hi, mode_select_pin_lo, cpu_addr} = 18'h20000;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    pin_reset();
    t_int();
    d(2'h1, 1'b1, 16'h004B, RGN_EXT);
    d(2'h1, 1'b1, 16'h004C, RGN_EXT);
    d(2'h1, 1'b1, 16'hF780, RGN_RAM);
    d(2'h1, 1'b0, 16'hFF7F, RGN_EXT);
    d(2'h1, 1'b1, 16'hFF80, RGN_EXT);
    d(2'h1, 1'b1, 16'hFFFF, RGN_IOREG);
    d(2'h2, 1'b1, 16'h0000, RGN_ROM);
    d(2'h2, 1'b1, 16'hBFFF, RGN_ROM);
    d(2'h2, 1'b1, 16'hC000, RGN_NONE);
    d(2'h2, 1'b1, 16'hEF80, RGN_EXT);
    d(2'h2, 1'b0, 16'hF780, RGN_EXT);
    d(2'h2, 1'b1, 16'hFF87, RGN_EXT);
    d(2'h3, 1'b1, 16'h004C, RGN_ROM);
    d(2'h3, 1'b1, 16'hFF80, RGN_NONE);
    d(2'h3, 1'b1, 16'hFF88, RGN_IOREG);
    standby_entry = 1'b1;
    d(2'h3, 1'b0, 16'hF780, RGN_NONE);
    standby_entry = 1'b0;
    `CHK("standby", 1'b0, onchip_ram_enable)
    {mode_select_pin_hi, mode_select_pin_lo} = 2'h2;
    i_rem_ext_model.lat = 3;
    t_wdt();
    nmi_pending = 1'b1;
    pin_reset();
    print_verdict();
  end
  // Whole run is near 630 cycles; this leaves ample margin
  initial begin
    #50000;
    n_mismatch++;
    print_verdict();
  end
endmodule
bind rem_reset_seq rem_properties i_rem_properties (.*);
